// ==== core/stbc_top.sv ====
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module stbc_top #(
    parameter int unsigned STAB_LONGEST = 262144
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [3:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   stop_exec,
    input  wire logic                   halt_exec,
    input  wire logic                   reset_req,
    input  wire logic [1:0]             cpu_clk_src,
    input  wire logic                   irq_pending,
    input  wire logic                   irq_ack_enable,
    input  wire logic                   watchdog_enable_option,
    input  wire logic                   watchdog_standby_run,
    input  wire logic                   adc_wakeup,
    input  wire logic                   serial_wakeup,
    output logic                        cpu_clk_en,
    output logic                        ram_en,
    output logic                        port_hold,
    output logic                        main_osc_en,
    output logic                        lowspeed_osc_en,
    output logic                        snooze,
    output logic                        resume,
    output logic                        vector_take,
    output logic                        reset_vector,
    output logic                        stop_refused,
    output stbc_pkg::stbc_run_t         run_en
);
    localparam int unsigned STAB_W = $clog2(STAB_LONGEST) + 1;

    if (STAB_LONGEST < (1 << (stbc_pkg::STAB_EXP_TOP - stbc_pkg::STAB_EXP[0])) ||
        (STAB_LONGEST & (STAB_LONGEST - 1)) != 0) begin : g_bad_longest
        $error("stbc_top: STAB_LONGEST must be a power of two of at least 1024");
    end
    if (stbc_pkg::GATE_CYC > stbc_pkg::GATE_MAX_LO_CYC) begin : g_bad_gate
        $error("stbc_top: release gating exceeds its upper bound");
    end

    stbc_pkg::stbc_state_t       state_q;
    stbc_pkg::stbc_state_t       state_d;
    stbc_pkg::stbc_clksrc_t      src_q;
    stbc_pkg::stbc_periph_cfg_t  pcfg_q;
    logic [1:0]                  ctrl_q;
    logic [2:0]                  stab_sel_q;
    logic [stbc_pkg::GATE_W-1:0] gate_cnt_q;
    logic [3:0]                  wait_cnt_q;
    logic [3:0]                  wait_len;
    logic [STAB_W-1:0]           stab_cnt_q;
    logic [STAB_W-1:0]           stab_thr [stbc_pkg::STAB_STEPS];
    logic [7:0]                  stab_status;
    logic                        stab_run_q;
    logic                        stab_done;
    logic                        vec_q;
    logic                        halted_q;
    logic                        src_ok;
    logic                        stop_take;
    logic                        gate_done;
    logic                        in_stop_d;
    logic                        snooze_set;

    // Stop mode accepted only from the three main clock sources
    assign src_ok    = stbc_pkg::stbc_clksrc_t'(cpu_clk_src) != stbc_pkg::SRC_OTHER;
    assign stop_take = (state_q == stbc_pkg::ST_RUN) && !halted_q && stop_exec && src_ok;
    assign gate_done = gate_cnt_q >= stbc_pkg::GATE_W'(stbc_pkg::GATE_CYC - 1);
    assign stab_done = stab_cnt_q >= stab_thr[stab_sel_q];
    assign snooze_set = (state_q == stbc_pkg::ST_STOP) && (src_q == stbc_pkg::SRC_HOCO)
                        && (adc_wakeup || serial_wakeup);

    always_comb begin
        if (src_q == stbc_pkg::SRC_XTAL) begin
            wait_len = vec_q ? stbc_pkg::WAIT_VEC_XTAL : stbc_pkg::WAIT_NOVEC_XTAL;
        end else begin
            wait_len = vec_q ? stbc_pkg::WAIT_VEC_FAST : stbc_pkg::WAIT_NOVEC_FAST;
        end
    end

    always_comb begin
        state_d = state_q;
        if (reset_req) begin
            state_d = stbc_pkg::ST_RUN;
        end else begin
            case (state_q)
                stbc_pkg::ST_RUN: begin
                    if (stop_take) begin
                        // A pending unmasked request clears stop at once but still pays release time
                        state_d = irq_pending ? stbc_pkg::ST_GATE : stbc_pkg::ST_STOP;
                    end
                end
                stbc_pkg::ST_STOP: begin
                    if (irq_pending) begin
                        state_d = stbc_pkg::ST_GATE;
                    end
                end
                stbc_pkg::ST_GATE: begin
                    if (gate_done && (src_q != stbc_pkg::SRC_XTAL || stab_done)) begin
                        state_d = stbc_pkg::ST_WAIT;
                    end
                end
                stbc_pkg::ST_WAIT: begin
                    if (wait_cnt_q == wait_len - 4'h1) begin
                        state_d = stbc_pkg::ST_RUN;
                    end
                end
                default: state_d = stbc_pkg::ST_RUN;
            endcase
        end
    end

    assign in_stop_d = (state_d == stbc_pkg::ST_STOP) || (state_d == stbc_pkg::ST_GATE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= stbc_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_q <= stbc_pkg::SRC_HOCO;
            vec_q <= 1'b0;
        end else begin
            if (stop_take) begin
                src_q <= stbc_pkg::stbc_clksrc_t'(cpu_clk_src);
            end
            if (state_q != stbc_pkg::ST_GATE && state_d == stbc_pkg::ST_GATE) begin
                vec_q <= irq_ack_enable;
            end
        end
    end

    // Release timing counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_cnt_q <= '0;
            wait_cnt_q <= 4'h0;
        end else begin
            if (state_q == stbc_pkg::ST_GATE && !gate_done) begin
                gate_cnt_q <= gate_cnt_q + stbc_pkg::GATE_W'(1);
            end else if (state_q != stbc_pkg::ST_GATE) begin
                gate_cnt_q <= '0;
            end
            wait_cnt_q <= (state_q == stbc_pkg::ST_WAIT) ? wait_cnt_q + 4'h1 : 4'h0;
        end
    end

    // Stabilisation counter counts crystal periods, one per clock, up to the selected time only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stab_cnt_q <= '0;
            stab_run_q <= 1'b0;
        end else if (stop_take) begin
            // A stop cleared at once goes straight to gating, so the count must start here
            stab_cnt_q <= '0;
            stab_run_q <= (state_d == stbc_pkg::ST_GATE);
        end else if (state_q == stbc_pkg::ST_STOP && state_d == stbc_pkg::ST_GATE) begin
            stab_run_q <= 1'b1;
        end else if (stab_run_q && !stab_done) begin
            stab_cnt_q <= stab_cnt_q + STAB_W'(1);
        end else begin
            stab_run_q <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < stbc_pkg::STAB_STEPS; gi++) begin : g_stab
            assign stab_thr[gi] = STAB_W'(STAB_LONGEST >> (stbc_pkg::STAB_EXP_TOP - stbc_pkg::STAB_EXP[gi]));
            stbc_stab_flag #(
                .W      (STAB_W),
                .THRESH (STAB_LONGEST >> (stbc_pkg::STAB_EXP_TOP - stbc_pkg::STAB_EXP[gi]))
            ) u_flag (
                .clk    (clk),
                .rst    (rst),
                .clear  (stop_take),
                .count  (stab_cnt_q),
                .flag   (stab_status[stbc_pkg::STAB_STEPS - 1 - gi])
            );
        end
    endgenerate

    // Halt ends on an interrupt or on any reset request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halted_q <= 1'b0;
        end else if (reset_req || irq_pending) begin
            halted_q <= 1'b0;
        end else if (halt_exec && state_q == stbc_pkg::ST_RUN) begin
            halted_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            snooze <= 1'b0;
        end else if (state_d != stbc_pkg::ST_STOP) begin
            snooze <= 1'b0;
        end else if (snooze_set) begin
            snooze <= 1'b1;
        end
    end

    // Clock and core gating follow the next state so outputs line up with state_q
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_clk_en      <= 1'b1;
            ram_en          <= 1'b1;
            port_hold       <= 1'b0;
            main_osc_en     <= 1'b1;
            lowspeed_osc_en <= 1'b1;
        end else begin
            cpu_clk_en      <= !in_stop_d && (reset_req || irq_pending
                               || !(halted_q || (halt_exec && state_q == stbc_pkg::ST_RUN)));
            ram_en          <= !in_stop_d;
            port_hold       <= in_stop_d;
            main_osc_en     <= (state_d != stbc_pkg::ST_STOP) || snooze || snooze_set;
            lowspeed_osc_en <= !in_stop_d || ctrl_q[stbc_pkg::CTRL_LOCO_BIT]
                               || (watchdog_enable_option && watchdog_standby_run);
        end
    end

    // Peripheral run enables follow the next state; interval timer, PGA, event link and always-on are never gated
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_en <= '1;
        end else begin
            run_en.interval_timer <= 1'b1;
            run_en.timer_array    <= !in_stop_d;
            run_en.motor_timer    <= !in_stop_d;
            run_en.clk_buzzer_out <= !in_stop_d;
            run_en.event_timer    <= !in_stop_d || pcfg_q.evt_lowspeed_clk
                                     || (pcfg_q.evt_count_mode && !pcfg_q.evt_filter_sel);
            run_en.serial_wake    <= !in_stop_d || (src_q == stbc_pkg::SRC_HOCO);
            run_en.serial_other   <= !in_stop_d;
            run_en.adc_wake       <= in_stop_d;
            run_en.comparator     <= !in_stop_d || !pcfg_q.cmp_filter_use;
            run_en.pga            <= 1'b1;
            run_en.event_link     <= 1'b1;
            run_en.always_on      <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resume       <= 1'b0;
            vector_take  <= 1'b0;
            reset_vector <= 1'b0;
            stop_refused <= 1'b0;
        end else begin
            resume       <= !reset_req && state_q == stbc_pkg::ST_WAIT && state_d == stbc_pkg::ST_RUN;
            vector_take  <= !reset_req && state_q == stbc_pkg::ST_WAIT && state_d == stbc_pkg::ST_RUN
                            && vec_q;
            reset_vector <= reset_req;
            stop_refused <= stop_exec && state_q == stbc_pkg::ST_RUN && !src_ok;
        end
    end

    // Register writes; the stabilisation select is frozen while a count runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q     <= stbc_pkg::CTRL_RESET;
            stab_sel_q <= stbc_pkg::STAB_SEL_RESET;
            pcfg_q     <= stbc_pkg::PERIPH_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                stbc_pkg::ADDR_CTRL:     ctrl_q <= reg_wdata[1:0];
                stbc_pkg::ADDR_STAB_SEL: begin
                    if (!stab_run_q) begin
                        stab_sel_q <= reg_wdata[2:0];
                    end
                end
                stbc_pkg::ADDR_PERIPH:   pcfg_q <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                stbc_pkg::ADDR_CTRL:      reg_rdata <= {6'h00, ctrl_q};
                stbc_pkg::ADDR_STAB_SEL:  reg_rdata <= {5'h00, stab_sel_q};
                stbc_pkg::ADDR_PERIPH:    reg_rdata <= {4'h0, pcfg_q};
                stbc_pkg::ADDR_STAB_STAT: reg_rdata <= stab_status;
                stbc_pkg::ADDR_STATUS:    reg_rdata <= {2'h0, src_q, snooze, halted_q, state_q};
                default:                  reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Observer of gating length, independent of the gate counter
    logic [10:0] obs_gate_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            obs_gate_q <= 11'h000;
        end else begin
            obs_gate_q <= (state_q == stbc_pkg::ST_GATE) ? obs_gate_q + 11'h001 : 11'h000;
        end
    end

    AST_RESET_RELEASES: assert property (@(posedge clk) disable iff (rst)
        reset_req |=> (state_q == stbc_pkg::ST_RUN) && !halted_q && reset_vector)
        else $error("reset request did not restart the core");

    AST_STOP_SRC_GUARD: assert property (@(posedge clk) disable iff (rst)
        (state_q == stbc_pkg::ST_RUN && stop_exec && cpu_clk_src == 2'h3 && !reset_req)
        |=> state_q == stbc_pkg::ST_RUN ##0 stop_refused)
        else $error("stop entered from a forbidden clock source");

    AST_IMMEDIATE_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (stop_take && irq_pending && !reset_req) |=> state_q == stbc_pkg::ST_GATE && !cpu_clk_en)
        else $error("pending interrupt did not clear stop at once");

    AST_CLOCKS_CUT: assert property (@(posedge clk) disable iff (rst)
        (state_q == stbc_pkg::ST_STOP && !snooze) |-> !cpu_clk_en && !main_osc_en)
        else $error("clock running in stop");

    AST_LOCO_SELECT: assert property (@(posedge clk) disable iff (rst)
        state_q == stbc_pkg::ST_STOP |-> lowspeed_osc_en ==
        ($past(ctrl_q[stbc_pkg::CTRL_LOCO_BIT]) || ($past(watchdog_enable_option) && $past(watchdog_standby_run))))
        else $error("low-speed oscillator state wrong in stop");

    AST_CORE_HELD: assert property (@(posedge clk) disable iff (rst)
        state_q == stbc_pkg::ST_STOP |-> port_hold && !ram_en && run_en.interval_timer && !run_en.timer_array)
        else $error("core or peripherals not held in stop");

    AST_IRQ_RELEASE: assert property (@(posedge clk) disable iff (rst)
        (state_q == stbc_pkg::ST_STOP && irq_pending && !reset_req) |=> state_q == stbc_pkg::ST_GATE)
        else $error("interrupt did not release stop");

    AST_GATE_FAST: assert property (@(posedge clk) disable iff (rst)
        ($past(state_q) == stbc_pkg::ST_GATE && state_q == stbc_pkg::ST_WAIT && src_q != stbc_pkg::SRC_XTAL)
        |-> obs_gate_q >= 11'd180 && obs_gate_q <= 11'd650)
        else $error("release gating outside its window");

    AST_GATE_XTAL: assert property (@(posedge clk) disable iff (rst)
        ($past(state_q) == stbc_pkg::ST_GATE && state_q == stbc_pkg::ST_WAIT && src_q == stbc_pkg::SRC_XTAL)
        |-> obs_gate_q >= 11'd180 && stab_done)
        else $error("crystal release ended early");

    AST_WAIT_FAST_VEC: assert property (@(posedge clk) disable iff (rst || reset_req)
        (state_q == stbc_pkg::ST_GATE ##1 state_q == stbc_pkg::ST_WAIT && vec_q && src_q != stbc_pkg::SRC_XTAL)
        |-> (state_q == stbc_pkg::ST_WAIT) [*7] ##1 (state_q == stbc_pkg::ST_RUN && vector_take))
        else $error("vectored wait is not seven clocks");

    AST_WAIT_XTAL_NOVEC: assert property (@(posedge clk) disable iff (rst || reset_req)
        (state_q == stbc_pkg::ST_GATE ##1 state_q == stbc_pkg::ST_WAIT && !vec_q && src_q == stbc_pkg::SRC_XTAL)
        |-> (state_q == stbc_pkg::ST_WAIT) [*4] ##1 (state_q == stbc_pkg::ST_RUN && resume && !vector_take))
        else $error("crystal plain wait is not four clocks");

    AST_STAB_ORDER: assert property (@(posedge clk) disable iff (rst)
        ((stab_status & ~(stab_status >> 1)) & 8'h7f) == 8'h00)
        else $error("stabilisation status not set in order");
endmodule : stbc_top

// ==== core/stbc_pkg.sv ====
package stbc_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned GATE_MIN_NS     = 18000;
    localparam int unsigned GATE_MAX_LO_NS  = 65000;
    localparam int unsigned GATE_MAX_HI_NS  = 135000;
    localparam int unsigned GATE_CYC        = (GATE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GATE_MAX_LO_CYC = GATE_MAX_LO_NS / CLK_PERIOD_NS;
    localparam int unsigned GATE_MAX_HI_CYC = GATE_MAX_HI_NS / CLK_PERIOD_NS;
    localparam int unsigned GATE_W          = $clog2(GATE_MAX_HI_CYC + 1);

    localparam logic [3:0] WAIT_VEC_FAST    = 4'h7;
    localparam logic [3:0] WAIT_NOVEC_FAST  = 4'h1;
    localparam logic [3:0] WAIT_VEC_XTAL    = 4'ha;
    localparam logic [3:0] WAIT_NOVEC_XTAL  = 4'h4;

    localparam int unsigned STAB_STEPS      = 8;
    localparam int unsigned STAB_EXP_TOP    = 18;
    localparam int unsigned STAB_EXP [STAB_STEPS] = '{8, 9, 10, 11, 13, 15, 17, 18};

    localparam logic [3:0] ADDR_CTRL        = 4'h0;
    localparam logic [3:0] ADDR_STAB_SEL    = 4'h1;
    localparam logic [3:0] ADDR_PERIPH      = 4'h2;
    localparam logic [3:0] ADDR_STAB_STAT   = 4'h3;
    localparam logic [3:0] ADDR_STATUS      = 4'h4;

    localparam int unsigned CTRL_FRQ_BIT    = 0;
    localparam int unsigned CTRL_LOCO_BIT   = 1;
    localparam logic [1:0] CTRL_RESET       = 2'h0;
    localparam logic [2:0] STAB_SEL_RESET   = 3'h7;

    typedef enum logic [1:0] {
        ST_RUN  = 2'h0,
        ST_STOP = 2'h1,
        ST_GATE = 2'h3,
        ST_WAIT = 2'h2
    } stbc_state_t;

    typedef enum logic [1:0] {
        SRC_HOCO  = 2'h0,
        SRC_XTAL  = 2'h1,
        SRC_EXT   = 2'h2,
        SRC_OTHER = 2'h3
    } stbc_clksrc_t;

    typedef struct packed {
        logic cmp_filter_use;
        logic evt_lowspeed_clk;
        logic evt_filter_sel;
        logic evt_count_mode;
    } stbc_periph_cfg_t;

    localparam stbc_periph_cfg_t PERIPH_RESET = 4'h0;

    typedef struct packed {
        logic interval_timer;
        logic timer_array;
        logic motor_timer;
        logic clk_buzzer_out;
        logic event_timer;
        logic serial_wake;
        logic serial_other;
        logic adc_wake;
        logic comparator;
        logic pga;
        logic event_link;
        logic always_on;
    } stbc_run_t;
endpackage : stbc_pkg

// ==== core/stbc_stab_flag.sv ====
`timescale 1ns/1ps
// One stabilisation status bit: sets when the count reaches its threshold and holds
module stbc_stab_flag #(
    parameter int unsigned W      = 19,
    parameter int unsigned THRESH = 256
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clear,
    input  wire logic [W-1:0] count,
    output logic              flag
);
    if (THRESH < 1 || THRESH >= (1 << W)) begin : g_bad_thresh
        $error("stbc_stab_flag: threshold out of range");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (clear) begin
            flag <= 1'b0;
        end else if (count >= W'(THRESH)) begin
            flag <= 1'b1;
        end
    end
endmodule : stbc_stab_flag

// ==== bench/stbc_cpu_model.sv ====
`timescale 1ns/1ps
module stbc_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic        irq_now,
    input  wire logic [11:0] wake_dly,
    input  wire logic        done,
    output logic             stop_exec,
    output logic             irq_pending
);
    logic        armed_q;
    logic [11:0] cnt_q;
    // Request flag stays up until the block answers, as a real flag would
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_exec   <= 1'h0;
            irq_pending <= 1'h0;
            armed_q     <= 1'h0;
            cnt_q       <= 12'h000;
        end else begin
            stop_exec   <= go;
            irq_pending <= (irq_pending & ~done) | irq_now | (armed_q & cnt_q == 12'h000);
            armed_q     <= go | (armed_q & ~done & cnt_q != 12'h000);
            cnt_q       <= go ? wake_dly : cnt_q - 12'h001;
        end
    end
endmodule : stbc_cpu_model

// ==== bench/stop_standby_controller_test.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin bad_count++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module stop_standby_controller_test;
    typedef struct packed {logic [1:0] src; logic ack, ls, we, ws, lo; logic [3:0] w;} stbc_row_t;
    stbc_row_t rows [6] = '{'{2'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 4'h7}, '{2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'h1},
        '{2'h2, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'h7}, '{2'h2, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 4'h1},
        '{2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 4'ha}, '{2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 4'h4}};
    logic clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, halt_exec = 1'h0, reset_req = 1'h0, ack = 1'h0;
    logic we = 1'h0, ws = 1'h0, go = 1'h0, irq_now = 1'h0, vt, cpu_clk_en, ram_en, port_hold;
    logic main_osc_en, lo_en, snooze, resume, vector_take, reset_vector, stop_refused, stop_exec, irq_pending;
    logic [1:0]  src = 2'h0, wk = 2'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, rdv, reg_rdata;
    logic [11:0] dly = 12'h014;
    stbc_pkg::stbc_run_t run_en;
    int bad_count = 0, comparisons = 0, n;
    always #50 clk = ~clk;
    stbc_top #(.STAB_LONGEST(1024)) u_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_exec,
        .halt_exec, .reset_req, .cpu_clk_src(src), .irq_pending, .irq_ack_enable(ack), .watchdog_enable_option(we),
        .watchdog_standby_run(ws), .adc_wakeup(wk[0]), .serial_wakeup(wk[1]), .cpu_clk_en, .ram_en, .port_hold,
        .main_osc_en, .lowspeed_osc_en(lo_en), .snooze, .resume, .vector_take, .reset_vector, .stop_refused, .run_en);
    stbc_cpu_model u_cpu (.clk, .rst, .go, .irq_now, .wake_dly(dly), .done(resume | reset_vector | stop_refused),
        .stop_exec, .irq_pending);
    task close_out;
        $display("Counts: %0d compared, %0d bad", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 rdv = reg_rdata;
    endtask : rd
    task stop_run(input logic now);
        @(posedge clk);
        go <= 1'h1;
        irq_now <= now;
        @(posedge clk);
        go <= 1'h0;
        irq_now <= 1'h0;
        #1;
    endtask : stop_run
    // Bounded waits: a dead release shows up as a count of 3000, not a hang
    task wake(output int c);
        c = 0;
        while (irq_pending !== 1'h1 && c < 3000) begin @(posedge clk); #1 c++; end
        c = 0;
        while (resume !== 1'h1 && c < 3000) begin @(posedge clk); #1 c++; end
        vt = vector_take;
    endtask : wake
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(4'h1);
        `CHK("stab_sel", 8'h07, rdv)
        rd(4'h5);
        `CHK("unmapped", 8'h00, rdv)
        wr(4'h1, 8'h00);
        foreach (rows[i]) begin
            src <= rows[i].src;
            ack <= rows[i].ack;
            we <= rows[i].we;
            ws <= rows[i].ws;
            wr(4'h0, {6'h00, rows[i].ls, 1'h0});
            stop_run(1'h0);
            repeat (3) @(posedge clk);
            #1;
            `CHK("lowspeed", rows[i].lo, lo_en)
            `CHK("gates", 4'h2, {cpu_clk_en, ram_en, port_hold, main_osc_en})
            `CHK("blocks", {5'h10, (rows[i].src == 2'h0), 6'h1f}, run_en)
            wake(n);
            `CHK("release", 1'h1, n >= 180 + rows[i].w && n <= 183 + rows[i].w)
            `CHK("vector", rows[i].ack, vt)
            $display("Row %0d released in %0d cycles", i, n);
        end
        rd(4'h3);
        `CHK("stab_status", 8'h80, rdv)
        src <= 2'h1;
        stop_run(1'h1);
        wake(n);
        `CHK("at_once", 1'h1, n >= 184 && n <= 187)
        src <= 2'h3;
        stop_run(1'h0);
        @(posedge clk);
        #1;
        `CHK("refused", 2'h3, {stop_refused, cpu_clk_en})
        src <= 2'h0;
        wr(4'h2, 8'h01);
        for (int j = 0; j < 2; j++) begin
            stop_run(1'h0);
            @(posedge clk);
            wk <= 2'h1 << j;
            @(posedge clk);
            wk <= 2'h0;
            repeat (2) @(posedge clk);
            #1;
            `CHK("snooze", 3'h7, {snooze, main_osc_en, run_en.event_timer})
            wake(n);
        end
        for (int k = 0; k < 2; k++) begin
            if (k == 0) stop_run(1'h0);
            else begin @(posedge clk); halt_exec <= 1'h1; @(posedge clk); halt_exec <= 1'h0; end
            repeat (2) @(posedge clk);
            #1;
            `CHK("held", 1'h0, cpu_clk_en)
            @(posedge clk);
            reset_req <= 1'h1;
            @(posedge clk);
            reset_req <= 1'h0;
            #1;
            `CHK("reset", 2'h3, {reset_vector, cpu_clk_en})
        end
        $display("Awkward cases done");
        close_out;
    end
    initial begin
        #(100 * 20000);
        bad_count++;
        close_out;
    end
endmodule : stop_standby_controller_test
